// *** rtl/acc_top.sv ***
// comparator control logic: AXI4-Lite slave, edge detect, flag and interrupt
// assumes analog core outside: it compares the chosen input with the negative pin
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "acc_params.svh"
module acc_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        stop_deep_wake,
   input  wire logic        cmp_raw,
   output logic             cmp_power_on,
   output logic             cmp_ref_select,
   output logic             result_output_pin,
   output logic             irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import acc_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic        on;
      logic        refsel;
      logic        flag;
      logic        irqen;
      logic        pinen;
      acc_edge_t   mode;
      logic        mask;
      logic        live;
      logic        pin;
      logic        irq;
      logic        awready;
      logic        wready;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } acc_state_t;

   acc_state_t st_r;
   acc_state_t st_nxt;
   logic       clr_n;
   logic       rise;
   logic       fall;
   logic       event_hit;
   logic       clr_flag;
   logic       wr_go;
   logic [7:0] csr_view;

   acc_sync_if sy ();

   // deep-stop wake is handled as reset so the block comes back clean
   assign clr_n = aresetn & ~stop_deep_wake;

   acc_sync u_sync (
      .aclk  (aclk),
      .clr_n (clr_n),
      .raw   (cmp_raw),
      .sy    (sy)
   );

   // ****************************************
   // edge select
   // ****************************************
   assign rise = sy.cur & ~sy.prev;
   assign fall = ~sy.cur & sy.prev;

   always_comb begin
      case (st_r.mode)
         ACC_RISE: event_hit = rise;
         ACC_BOTH: event_hit = rise | fall;
         ACC_FALL0,
         ACC_FALL2: event_hit = fall;
         default:  event_hit = 1'b0;
      endcase
   end

   assign csr_view = {st_r.on, st_r.refsel, st_r.flag, st_r.irqen,
                      st_r.live, st_r.pinen, st_r.mode};

   // both halves captured before the write acts, so no channel is lost
   assign wr_go    = st_r.aw_got & st_r.w_got & ~st_r.bvalid;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [7:0]  wa;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic        ok;
      wa       = st_r.aw_addr;
      wd       = st_r.w_data;
      ws       = st_r.w_strb;
      ok       = 1'b0;
      clr_flag = 1'b0;
      st_nxt   = st_r;

      // write channels taken in either order
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end
      if (wr_go) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         case (wa)
            `ACC_OFF_CSR: begin
               ok = 1'b1;
               if (ws[0]) begin
                  st_nxt.on     = wd[`ACC_BIT_ON];
                  st_nxt.refsel = wd[`ACC_BIT_REFSEL];
                  st_nxt.irqen  = wd[`ACC_BIT_IRQEN];
                  st_nxt.pinen  = wd[`ACC_BIT_PINEN];
                  st_nxt.mode   = acc_edge_t'(wd[1:0]);
                  clr_flag      = wd[`ACC_BIT_FLAG];
               end
            end
            `ACC_OFF_IRQ_STAT: begin
               ok = 1'b1;
               if (ws[0]) begin
                  clr_flag = wd[0];
               end
            end
            `ACC_OFF_IRQ_MASK: begin
               ok = 1'b1;
               if (ws[0]) begin
                  st_nxt.mask = wd[0];
               end
            end
            default: ok = 1'b0;
         endcase
         st_nxt.bresp = ok ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // read: arready stands while idle, data follows the address handshake
      if (s_axi_arvalid && st_r.arready) begin
         st_nxt.rvalid  = 1'b1;
         st_nxt.rresp   = `ACC_RESP_OKAY;
         case (s_axi_araddr)
            `ACC_OFF_CSR:      st_nxt.rdata = {24'h0, csr_view};
            `ACC_OFF_IRQ_STAT: st_nxt.rdata = {31'h0, st_r.flag};
            `ACC_OFF_IRQ_MASK: st_nxt.rdata = {31'h0, st_r.mask};
            default: begin
               st_nxt.rdata = 32'h0;
               st_nxt.rresp = `ACC_RESP_SLVERR;
            end
         endcase
      end
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end

      // flag: set wins over a clear in the same cycle
      if (clr_flag) begin
         st_nxt.flag = 1'b0;
      end
      if (st_r.on && event_hit) begin
         st_nxt.flag = 1'b1;
      end

      st_nxt.live = st_r.on ? sy.cur : 1'b0;
      st_nxt.pin  = st_r.on & st_r.pinen & sy.cur;
      st_nxt.irq  = st_nxt.flag & st_nxt.irqen & st_nxt.mask;

      // ready flops: low while a transfer is held, so nothing is taken twice
      st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
      st_nxt.wready  = ~st_nxt.w_got & ~st_nxt.bvalid;
      st_nxt.arready = ~st_nxt.rvalid;

      if (!clr_n) begin
         st_nxt      = '0;
         st_nxt.mask = `ACC_MASK_RESET;
      end
   end

   always_ff @(posedge aclk) begin
      st_r <= st_nxt;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign cmp_power_on      = st_r.on;
   assign cmp_ref_select    = st_r.refsel;
   assign result_output_pin = st_r.pin;
   assign irq               = st_r.irq;
   assign s_axi_awready     = st_r.awready;
   assign s_axi_wready      = st_r.wready;
   assign s_axi_bvalid      = st_r.bvalid;
   assign s_axi_bresp       = st_r.bresp;
   assign s_axi_arready     = st_r.arready;
   assign s_axi_rvalid      = st_r.rvalid;
   assign s_axi_rdata       = st_r.rdata;
   assign s_axi_rresp       = st_r.rresp;

   // ****************************************
   // checks
   // ****************************************
   a_live_off_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_r.on |=> !st_r.live) else $error("live bit set while disabled");
   a_live_follows: assert property (@(posedge aclk) disable iff (!clr_n)
      st_r.on && $stable(st_r.on) |-> st_r.live == $past(sy.cur))
      else $error("live bit lags result");
   a_flag_on_rise: assert property (@(posedge aclk) disable iff (!clr_n)
      st_r.on && st_r.mode == ACC_RISE && rise |=> st_r.flag)
      else $error("rise missed");
   a_flag_on_fall: assert property (@(posedge aclk) disable iff (!clr_n)
      st_r.on && st_r.mode == ACC_FALL2 && fall |=> st_r.flag)
      else $error("fall missed");
   a_flag_holds: assert property (@(posedge aclk) disable iff (!clr_n)
      st_r.flag && !clr_flag |=> st_r.flag) else $error("flag lost");
   a_flag_noevt: assert property (@(posedge aclk) disable iff (!clr_n)
      !st_r.flag && !(st_r.on && event_hit) |=> !st_r.flag)
      else $error("flag set spuriously");
   a_irq_follow: assert property (@(posedge aclk) disable iff (!clr_n)
      st_r.flag && st_r.irqen && st_r.mask |-> st_r.irq)
      else $error("irq missing");
   a_pin_gated: assert property (@(posedge aclk) disable iff (!clr_n)
      !st_r.pinen ##1 !st_r.pinen |-> !st_r.pin) else $error("pin driven");
   a_reset_clear: assert property (@(posedge aclk)
      !aresetn |=> st_r.on == 1'b0 && st_r.flag == 1'b0 && !irq)
      else $error("reset state wrong");
   a_bvalid_holds: assert property (@(posedge aclk) disable iff (!clr_n)
      st_r.bvalid && !s_axi_bready |=> st_r.bvalid)
      else $error("write response dropped");
   a_rvalid_holds: assert property (@(posedge aclk) disable iff (!clr_n)
      st_r.rvalid && !s_axi_rready |=> st_r.rvalid && $stable(st_r.rdata))
      else $error("read response dropped");
endmodule // acc_top
`default_nettype wire

// *** rtl/acc_params.svh ***
// constants for the comparator control block: offsets, fields, reset values
// assumes inclusion by the top module and the bench only
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_OFF_CSR      8'h00
`define ACC_OFF_IRQ_STAT 8'h04
`define ACC_OFF_IRQ_MASK 8'h08
`define ACC_BIT_ON       7
`define ACC_BIT_REFSEL   6
`define ACC_BIT_FLAG     5
`define ACC_BIT_IRQEN    4
`define ACC_BIT_LIVE     3
`define ACC_BIT_PINEN    2
`define ACC_CSR_RESET    8'h00
`define ACC_MASK_RESET   1'b1
`define ACC_RESP_OKAY    2'b00
`define ACC_RESP_SLVERR  2'b10
`endif

// *** rtl/acc_pkg.sv ***
// types for the comparator control block
// assumes acc_params.svh sits beside it
package acc_pkg;
   typedef enum logic [1:0] {
      ACC_FALL0,
      ACC_RISE,
      ACC_FALL2,
      ACC_BOTH
   } acc_edge_t;
endpackage

// *** rtl/acc_sync_if.sv ***
// interface carrying the synchronised comparator result to the top
// assumes one clock domain, aclk
`timescale 1ns/1ps
`default_nettype none
interface acc_sync_if;
   logic cur;
   logic prev;
   modport src (output cur, output prev);
   modport dst (input cur, input prev);
endinterface
`default_nettype wire

// *** rtl/acc_sync.sv ***
// two-stage synchroniser plus previous-sample register for the comparator
// assumes raw input is asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module acc_sync (
   input  wire logic aclk,
   input  wire logic clr_n,
   input  wire logic raw,
   acc_sync_if.src   sy
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } acc_sync_st_t;
   acc_sync_st_t st_r;
   acc_sync_st_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = raw;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (!clr_n) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge aclk) begin
      st_r <= st_nxt;
   end

   assign sy.cur  = st_r.s2;
   assign sy.prev = st_r.s3;
endmodule // acc_sync
`default_nettype wire

// *** test/acc_analog_model.sv ***
// behavioural analog comparator core beside the control block
// assumes the bench sets the pin and bandgap voltages as reals
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
   input  var  real  pos_v,
   input  var  real  neg_v,
   input  var  real  bg_v,
   input  wire logic cmp_ref_select,
   output logic      cmp_raw
);
   real noninv;
   // not gated by power: the block itself must hide the result when off
   always_comb begin
      noninv = cmp_ref_select ? bg_v : pos_v;
      cmp_raw = noninv > neg_v;
   end
endmodule // acc_analog_model
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench: register bus, edge modes, interrupt, resets
// assumes acc_top and acc_analog_model compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "acc_params.svh"
module tb_top;
   logic        aclk, aresetn, stop_deep_wake, cmp_raw, pwr, rsel, pin, irq, f;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd;
   logic [1:0]  bresp, rresp, rs;
   real         pos_v, neg_v, bg_v;
   int          failures, total_checks, cyc;

   acc_analog_model core (.pos_v(pos_v), .neg_v(neg_v), .bg_v(bg_v),
      .cmp_ref_select(rsel), .cmp_raw(cmp_raw));
   acc_top dut (.aclk(aclk), .aresetn(aresetn), .stop_deep_wake(stop_deep_wake),
      .cmp_raw(cmp_raw), .cmp_power_on(pwr), .cmp_ref_select(rsel),
      .result_output_pin(pin), .irq(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));

   always #2 aclk = ~aclk;

   // ****************************************
   // bus and check helpers
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      chk(rd, e, m);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_live();
      wr(`ACC_OFF_CSR, 32'hc4);
      tick(8);
      rc(`ACC_OFF_CSR, 32'hcc, "live high");
      chk({29'h0, pwr, rsel, pin}, 32'h7, "pins on");
      neg_v <= 2.0;
      tick(8);
      rc(`ACC_OFF_CSR, 32'he4, "live low");
      chk({31'h0, pin}, 32'h0, "pin low");
      neg_v <= 0.5;
      wr(`ACC_OFF_CSR, 32'he0);
      tick(8);
      chk({31'h0, pin}, 32'h0, "pin off");
      wr(`ACC_OFF_CSR, 32'h40);
      tick(8);
      rc(`ACC_OFF_CSR, 32'h40, "live while off");
      chk({31'h0, pwr}, 32'h0, "power off");
      wr(`ACC_OFF_CSR, 32'h00);
      $display("live test done");
   endtask
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         wr(`ACC_OFF_CSR, 32'hb0 | m);
         pos_v <= 1.0;
         tick(8);
         f = (m == 1 || m == 3);
         rc(`ACC_OFF_CSR, 32'h98 | m | (f ? 32'h20 : 32'h0), "rise");
         chk({31'h0, irq}, {31'h0, f}, "irq rise");
         wr(`ACC_OFF_CSR, 32'hb0 | m);
         pos_v <= 0.0;
         tick(8);
         f = (m != 1);
         rc(`ACC_OFF_CSR, 32'h90 | m | (f ? 32'h20 : 32'h0), "fall");
         chk({31'h0, irq}, {31'h0, f}, "irq fall");
      end
      $display("mode test done");
   endtask
   task automatic t_irq();
      wr(`ACC_OFF_CSR, 32'hb3);
      pos_v <= 1.0;
      tick(8);
      wr(`ACC_OFF_CSR, 32'h93);
      rc(`ACC_OFF_CSR, 32'hbb, "zero write kept");
      rc(`ACC_OFF_IRQ_STAT, 32'h1, "status");
      wr(`ACC_OFF_IRQ_MASK, 32'h0);
      tick(2);
      chk({31'h0, irq}, 32'h0, "masked");
      wr(`ACC_OFF_IRQ_MASK, 32'h1);
      tick(2);
      chk({31'h0, irq}, 32'h1, "unmasked");
      wr(`ACC_OFF_IRQ_STAT, 32'h1);
      rc(`ACC_OFF_CSR, 32'h9b, "cleared");
      chk({31'h0, irq}, 32'h0, "irq cleared");
      wr(`ACC_OFF_CSR, 32'h83);
      pos_v <= 0.0;
      tick(8);
      rc(`ACC_OFF_CSR, 32'ha3, "flag no irq");
      chk({31'h0, irq}, 32'h0, "irq disabled");
      wr(8'h0c, 32'hff);
      chk({30'h0, rs}, {30'h0, `ACC_RESP_SLVERR}, "bad write");
      rc(8'h0c, 32'h0, "bad read data");
      chk({30'h0, rs}, {30'h0, `ACC_RESP_SLVERR}, "bad read");
      $display("irq test done");
   endtask
   task automatic t_reset(input int k);
      rc(`ACC_OFF_CSR, 32'h0, "csr reset");
      rc(`ACC_OFF_IRQ_MASK, 32'h1, "mask reset");
      chk({28'h0, pwr, rsel, pin, irq}, 32'h0, "outs reset");
      if (k > 0) $display("reset test done");
   endtask

   task automatic finish_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // hang guard well above the few hundred cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         finish_test();
      end
   end

   initial begin
      {aclk, stop_deep_wake, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, failures, total_checks, cyc} = '0;
      aresetn = 1'b0;
      pos_v = 0.0;
      neg_v = 0.5;
      bg_v = 1.2;
      tick(5);
      aresetn <= 1'b1;
      t_reset(0);
      t_live();
      t_modes();
      t_irq();
      for (int k = 1; k < 3; k++) begin
         wr(`ACC_OFF_CSR, 32'hd7);
         if (k == 1) stop_deep_wake <= 1'b1;
         else aresetn <= 1'b0;
         tick(3);
         stop_deep_wake <= 1'b0;
         aresetn <= 1'b1;
         t_reset(k);
      end
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
